// ---- hdl/serial_ctrl_pkg.sv ----
package serial_ctrl_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK       = 8'h0c;
    localparam logic [7:0] ADDR_TX_DATA        = 8'h10;
    localparam logic [7:0] ADDR_RX_DATA        = 8'h14;
    localparam logic [7:0] ADDR_GIVEN          = 8'h18;
    localparam logic [7:0] ADDR_BROADCAST      = 8'h1c;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SC_RX_DONE    = 0;
    localparam int SC_TX_DONE    = 1;
    localparam int SC_RX_NINTH   = 2;
    localparam int SC_TX_NINTH   = 3;
    localparam int SC_RX_ENABLE  = 4;
    localparam int SC_MULTIPROC  = 5;
    localparam int SC_MODE_ONE   = 6;
    localparam int SC_BIT7       = 7;
    localparam int PC_ACCESS_SEL = 6;
    localparam int PC_BAUD_DBL   = 7;
    localparam int IRQ_TX        = 0;
    localparam int IRQ_RX        = 1;
    localparam int IRQ_FE        = 2;
    localparam int IRQ_W         = 3;
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] POWER_CONTROL_RESET  = 8'h00;

    // ----------------------------------------
    // Timing counts (sample ticks per bit), bit indices and bus response codes
    // ----------------------------------------
    localparam logic [3:0] TICK_LAST   = 4'hf;
    localparam logic [3:0] TICK_VOTE_A = 4'h7;
    localparam logic [3:0] TICK_VOTE_B = 4'h8;
    localparam logic [3:0] TICK_VOTE_C = 4'h9;
    localparam logic [3:0] M0_LAST_BIT = 4'h7;
    localparam logic [3:0] STOP_IDX_8  = 4'h9;
    localparam logic [3:0] STOP_IDX_9  = 4'ha;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR} serial_mode_type;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_lite_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_lite_rsp_type;

endpackage : serial_ctrl_pkg

// ---- hdl/baud_tick_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module baud_tick_gen
    import serial_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    // Rate selection
    input  wire serial_mode_type mode_i,
    input  wire logic            baud_double_i,
    input  wire logic            t1_overflow_i,
    // Sixteen ticks per bit time
    output var  logic            sample_tick_o
);
    typedef struct packed {
        logic half;
        logic tick;
    } state_type;

    state_type s_reg;
    state_type s_next;
    logic      src;

    always_comb
    begin
        // Fixed-rate mode counts the oscillator, others count timer overflows
        src = (mode_i == MODE_UART9_FIXED) ? 1'b1 : t1_overflow_i;  // [R14] [R15]
        s_next = s_reg;
        s_next.half = src ? ~s_reg.half : s_reg.half;
        s_next.tick = src && (baud_double_i || s_reg.half);         // [R14] [R15]
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign sample_tick_o = s_reg.tick;

endmodule : baud_tick_gen
`default_nettype wire

// ---- hdl/line_sampler.sv ----
`timescale 1ns/10ps
`default_nettype none
module line_sampler
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output var  logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } state_type;

    state_type s_reg;
    state_type s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.s1 = pin_i;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        // Change accepted only once two late stages agree
        if (s_reg.s2 == s_reg.s3)
            s_next.level = s_reg.s3;
    end

    // Idle line is high
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_reg <= '1;
        else
            s_reg <= s_next;
    end

    assign level_o = s_reg.level;

endmodule : line_sampler
`default_nettype wire

// ---- hdl/serial_port_control.sv ----
// Notes on behaviour
// R1: Bad stop bit sets framing flag, any select
// R2: Framing flag sticks; only software zero clears
// R3: Bit 7 shows framing flag or mode bit
// R4: Mode bits pick shift, 8-bit, 9-bit UARTs
// R5: Modes 2/3 address gate: ninth bit, match
// R6: Mode 1 address gate: valid stop, match
// R7: Software keeps multiprocessor enable zero in mode 0
// R8: Reception only while receive enable is one
// R9: Modes 2/3 send written ninth bit
// R10: Ninth-bit field captures ninth or stop bit
// R11: Transmit flag timing per mode, software clears
// R12: Receive flag timing per mode, software clears
// R13: Mode 0 runs at clock divided by two
// R14: Mode 2 rate clock/32, doubled to /16
// R15: Modes 1/3 rate from timer overflow
// R16: Reception start conditions per mode
// R17: Serial control register resets to zero
// R18: Zero stop bit counts as invalid
`timescale 1ns/10ps
`default_nettype none
module serial_port_control
    import serial_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Register bus
    input  wire axi_lite_req_type axi_req_i,
    output var  axi_lite_rsp_type axi_rsp_o,
    // Baud source
    input  wire logic             t1_overflow_i,
    // Serial pins
    input  wire logic             rxd_i,
    output var  logic             rxd_o,
    output var  logic             rxd_oe_o,
    output var  logic             txd_o,
    // Interrupt
    output var  logic             irq_o
);
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_SHIFT0} rx_state_type;

    typedef struct packed {
        logic         mode_bit_zero;
        logic         mode_bit_one;
        logic         multiproc_enable;
        logic         rx_enable;
        logic         tx_ninth_bit;
        logic         rx_ninth_bit;
        logic         tx_done_flag;
        logic         rx_done_flag;
        logic         framing_error_flag;
        logic         bit7_access_select;
        logic         baud_double;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [7:0]   rx_data;
        logic [7:0]   given_addr;
        logic [7:0]   bcast_addr;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   aw_addr;
        logic [7:0]   w_byte;
        logic         w_lane0;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic         tx_busy;
        logic [9:0]   tx_frame;
        logic [3:0]   tx_cnt;
        logic [3:0]   tx_bit;
        logic         tx_out;
        logic         sclk;
        rx_state_type rx_state;
        logic [3:0]   rx_cnt;
        logic [3:0]   rx_bit;
        logic [8:0]   rx_shift;
        logic         s7;
        logic         s8;
        logic         rx_prev;
    } state_type;

    state_type       s_reg;
    state_type       s_next;
    serial_mode_type mode;
    logic            sample_tick;
    logic            rx_level;
    logic [3:0]      stop_idx;
    logic            m0_run;
    logic            tx_set;
    logic            rx_set;
    logic            fe_set;
    logic            vote;
    logic [7:0]      rx_byte;
    logic            ninth;
    logic            gate;
    logic            aw_hs;
    logic            w_hs;
    logic            ar_hs;
    logic [7:0]      rd_byte;
    logic            rd_err;

    // ----------------------------------------
    // Rate and pin conditioning
    // ----------------------------------------
    assign mode = serial_mode_type'({s_reg.mode_bit_zero, s_reg.mode_bit_one});  // [R4]

    baud_tick_gen u_baud (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .mode_i        (mode),
        .baud_double_i (s_reg.baud_double),
        .t1_overflow_i (t1_overflow_i),
        .sample_tick_o (sample_tick)
    );

    line_sampler u_rx_pin (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pin_i   (rxd_i),
        .level_o (rx_level)
    );

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always_comb
    begin
        rd_err = 1'b0;
        case (axi_req_i.araddr)
            ADDR_SERIAL_CONTROL: rd_byte = {s_reg.bit7_access_select ? s_reg.framing_error_flag
                                                                   : s_reg.mode_bit_zero,  // [R3]
                                            s_reg.mode_bit_one, s_reg.multiproc_enable, s_reg.rx_enable,
                                            s_reg.tx_ninth_bit, s_reg.rx_ninth_bit,
                                            s_reg.tx_done_flag, s_reg.rx_done_flag};
            ADDR_POWER_CONTROL:  rd_byte = {s_reg.baud_double, s_reg.bit7_access_select, 6'h00};
            ADDR_IRQ_STATUS:     rd_byte = {5'h00, s_reg.irq_status};
            ADDR_IRQ_MASK:       rd_byte = {5'h00, s_reg.irq_mask};
            ADDR_TX_DATA:        rd_byte = 8'h00;
            ADDR_RX_DATA:        rd_byte = s_reg.rx_data;
            ADDR_GIVEN:          rd_byte = s_reg.given_addr;
            ADDR_BROADCAST:      rd_byte = s_reg.bcast_addr;
            default:
            begin
                rd_byte = 8'h00;
                rd_err  = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_next   = s_reg;
        tx_set   = 1'b0;
        rx_set   = 1'b0;
        fe_set   = 1'b0;
        vote     = 1'b0;
        stop_idx = (mode == MODE_UART8) ? STOP_IDX_8 : STOP_IDX_9;
        m0_run   = (mode == MODE_SHIFT) && (s_reg.tx_busy || s_reg.rx_state == RX_SHIFT0);
        aw_hs    = axi_req_i.awvalid && !s_reg.aw_got && !s_reg.bvalid;
        w_hs     = axi_req_i.wvalid && !s_reg.w_got && !s_reg.bvalid;
        ar_hs    = axi_req_i.arvalid && !s_reg.rvalid;
        rx_byte  = (mode == MODE_UART8) ? s_reg.rx_shift[8:1] : s_reg.rx_shift[7:0];
        ninth    = s_reg.rx_shift[8];
        gate     = 1'b0;

        // Shift clock toggles every cycle: one bit per two clocks
        if (m0_run)
            s_next.sclk = ~s_reg.sclk;  // [R13]

        // Transmitter
        if (s_reg.tx_busy)
        begin
            if (mode == MODE_SHIFT)
            begin
                if (s_reg.sclk)
                    s_next.tx_out = s_reg.tx_frame[s_reg.tx_bit];
                else if (s_reg.tx_bit == M0_LAST_BIT)
                begin
                    s_next.tx_busy = 1'b0;
                    s_next.tx_out  = 1'b1;
                    tx_set         = 1'b1;  // [R11]
                end
                else
                    s_next.tx_bit = s_reg.tx_bit + 4'h1;
            end
            else if (sample_tick)
            begin
                s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                if (s_reg.tx_cnt == TICK_LAST)
                begin
                    if (s_reg.tx_bit == stop_idx)
                        s_next.tx_busy = 1'b0;
                    else
                    begin
                        s_next.tx_bit = s_reg.tx_bit + 4'h1;
                        s_next.tx_out = s_reg.tx_frame[s_reg.tx_bit];
                        tx_set        = (s_reg.tx_bit + 4'h1) == stop_idx;  // [R11]
                    end
                end
            end
        end

        // Receiver
        s_next.rx_prev = rx_level;
        unique case (s_reg.rx_state)
            RX_IDLE:
            begin
                if (s_reg.rx_enable && mode == MODE_SHIFT && !s_reg.rx_done_flag && !s_reg.tx_busy)
                begin
                    s_next.rx_state = RX_SHIFT0;  // [R16] [R8]
                    s_next.rx_bit   = 4'h0;
                    s_next.sclk     = 1'b1;
                end
                else if (s_reg.rx_enable && mode != MODE_SHIFT && s_reg.rx_prev && !rx_level)
                begin
                    s_next.rx_state = RX_FRAME;  // [R16] [R8]
                    s_next.rx_cnt   = 4'h0;
                    s_next.rx_bit   = 4'h0;
                end
            end
            RX_SHIFT0:
            begin
                if (!s_reg.rx_enable)
                    s_next.rx_state = RX_IDLE;  // [R8]
                else if (!s_reg.sclk)
                begin
                    s_next.rx_shift = {rx_level, s_reg.rx_shift[8:1]};
                    if (s_reg.rx_bit == M0_LAST_BIT)
                    begin
                        s_next.rx_state = RX_IDLE;
                        s_next.rx_data  = {rx_level, s_reg.rx_shift[8:2]};
                        rx_set          = 1'b1;  // [R12]
                    end
                    else
                        s_next.rx_bit = s_reg.rx_bit + 4'h1;
                end
            end
            RX_FRAME:
            begin
                if (!s_reg.rx_enable)
                    s_next.rx_state = RX_IDLE;  // [R8]
                else if (sample_tick)
                begin
                    s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    if (s_reg.rx_cnt == TICK_VOTE_A)
                        s_next.s7 = rx_level;
                    if (s_reg.rx_cnt == TICK_VOTE_B)
                        s_next.s8 = rx_level;
                    if (s_reg.rx_cnt == TICK_LAST)
                        s_next.rx_bit = s_reg.rx_bit + 4'h1;
                    if (s_reg.rx_cnt == TICK_VOTE_C)
                    begin
                        // Two of three samples mid-bit reject noise
                        vote = (s_reg.s7 & s_reg.s8) | (s_reg.s7 & rx_level) | (s_reg.s8 & rx_level);
                        if (s_reg.rx_bit == 4'h0)
                        begin
                            if (vote)
                                s_next.rx_state = RX_IDLE;
                        end
                        else if (s_reg.rx_bit == stop_idx)
                        begin
                            // Mid stop bit; in mode 1 the stop bit stands in as ninth bit
                            s_next.rx_state = RX_IDLE;
                            if (mode == MODE_UART8)
                                ninth = vote;  // [R10]
                            fe_set = !vote;  // [R1] [R18]
                            gate   = !s_reg.multiproc_enable ||
                                     (ninth && (rx_byte == s_reg.given_addr || rx_byte == s_reg.bcast_addr));  // [R5] [R6]
                            // Unread byte is kept; the new one is dropped
                            if (!s_reg.rx_done_flag && gate)
                            begin
                                s_next.rx_data      = rx_byte;
                                s_next.rx_ninth_bit = ninth;  // [R10]
                                rx_set              = 1'b1;  // [R12]
                            end
                        end
                        else
                            s_next.rx_shift = {vote, s_reg.rx_shift[8:1]};
                    end
                end
            end
        endcase

        // Register bus
        if (aw_hs)
        begin
            s_next.aw_got  = 1'b1;
            s_next.aw_addr = axi_req_i.awaddr;
        end
        if (w_hs)
        begin
            s_next.w_got   = 1'b1;
            s_next.w_byte  = axi_req_i.wdata[7:0];
            s_next.w_lane0 = axi_req_i.wstrb[0];
        end
        if (s_reg.bvalid && axi_req_i.bready)
            s_next.bvalid = 1'b0;
        if (s_reg.rvalid && axi_req_i.rready)
            s_next.rvalid = 1'b0;
        if (ar_hs)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = {24'h000000, rd_byte};
            s_next.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_reg.aw_got && s_reg.w_got)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = RESP_OKAY;
            case (s_reg.aw_addr)
                ADDR_SERIAL_CONTROL:
                    if (s_reg.w_lane0)
                    begin
                        if (s_reg.bit7_access_select)
                            s_next.framing_error_flag = s_reg.w_byte[SC_BIT7];  // [R2] [R3]
                        else
                            s_next.mode_bit_zero = s_reg.w_byte[SC_BIT7];  // [R3]
                        s_next.mode_bit_one     = s_reg.w_byte[SC_MODE_ONE];
                        s_next.multiproc_enable = s_reg.w_byte[SC_MULTIPROC];
                        s_next.rx_enable        = s_reg.w_byte[SC_RX_ENABLE];  // [R8]
                        s_next.tx_ninth_bit     = s_reg.w_byte[SC_TX_NINTH];
                        s_next.rx_ninth_bit     = s_reg.w_byte[SC_RX_NINTH];
                        s_next.tx_done_flag     = s_reg.w_byte[SC_TX_DONE];  // [R11]
                        s_next.rx_done_flag     = s_reg.w_byte[SC_RX_DONE];  // [R12]
                    end
                ADDR_POWER_CONTROL:
                    if (s_reg.w_lane0)
                    begin
                        s_next.bit7_access_select = s_reg.w_byte[PC_ACCESS_SEL];
                        s_next.baud_double        = s_reg.w_byte[PC_BAUD_DBL];
                    end
                ADDR_IRQ_STATUS:
                    if (s_reg.w_lane0)
                        s_next.irq_status = s_reg.irq_status & ~s_reg.w_byte[IRQ_W-1:0];
                ADDR_IRQ_MASK:
                    if (s_reg.w_lane0)
                        s_next.irq_mask = s_reg.w_byte[IRQ_W-1:0];
                ADDR_TX_DATA:
                    // Write while busy, or during a mode 0 receive, is dropped
                    if (s_reg.w_lane0 && !s_reg.tx_busy && !(mode == MODE_SHIFT && s_reg.rx_state != RX_IDLE))
                    begin
                        s_next.tx_busy  = 1'b1;
                        s_next.tx_frame = {1'b1, (mode == MODE_UART8) ? 1'b1 : s_reg.tx_ninth_bit,
                                           s_reg.w_byte};  // [R9]
                        s_next.tx_bit   = 4'h0;
                        s_next.tx_cnt   = 4'h0;
                        s_next.tx_out   = (mode == MODE_SHIFT);
                        s_next.sclk     = 1'b1;
                    end
                ADDR_RX_DATA:
                    s_next.bresp = RESP_OKAY;
                ADDR_GIVEN:
                    if (s_reg.w_lane0)
                        s_next.given_addr = s_reg.w_byte;
                ADDR_BROADCAST:
                    if (s_reg.w_lane0)
                        s_next.bcast_addr = s_reg.w_byte;
                default:
                    s_next.bresp = RESP_SLVERR;
            endcase
        end

        // Hardware set beats a same-cycle software clear
        s_next.tx_done_flag       = s_next.tx_done_flag | tx_set;  // [R11]
        s_next.rx_done_flag       = s_next.rx_done_flag | rx_set;  // [R12]
        s_next.framing_error_flag = s_next.framing_error_flag | fe_set;  // [R1] [R2]
        s_next.irq_status         = s_next.irq_status | {fe_set, rx_set, tx_set};
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_reg         <= '0;  // [R17]
            s_reg.tx_out  <= 1'b1;
            s_reg.sclk    <= 1'b1;
            s_reg.rx_prev <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb
    begin
        axi_rsp_o         = '0;
        axi_rsp_o.awready = !s_reg.aw_got && !s_reg.bvalid;
        axi_rsp_o.wready  = !s_reg.w_got && !s_reg.bvalid;
        axi_rsp_o.bvalid  = s_reg.bvalid;
        axi_rsp_o.bresp   = s_reg.bresp;
        axi_rsp_o.arready = !s_reg.rvalid;
        axi_rsp_o.rvalid  = s_reg.rvalid;
        axi_rsp_o.rdata   = s_reg.rdata;
        axi_rsp_o.rresp   = s_reg.rresp;
    end

    // Mode 0: data on the receive pin, shift clock on the transmit pin
    assign rxd_o    = s_reg.tx_out;
    assign rxd_oe_o = (mode == MODE_SHIFT) && s_reg.tx_busy;
    assign txd_o    = (mode == MODE_SHIFT) ? s_reg.sclk : s_reg.tx_out;
    assign irq_o    = |(s_reg.irq_status & s_reg.irq_mask);

endmodule : serial_port_control
`default_nettype wire

// ---- tb/serial_port_control_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_port_control_sva
    import serial_ctrl_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_b_i,
    input wire axi_lite_req_type axi_req_i,
    input wire axi_lite_rsp_type axi_rsp_o,
    input wire logic             rxd_oe_o,
    input wire logic             txd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence wr_taken;
        axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
    endsequence
    sequence rd_taken;
        axi_req_i.arvalid && axi_rsp_o.arready;
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##[1:2] axi_rsp_o.bvalid)
        else $error("write answer missing");
    chk_read_answer: assert property (rd_taken |=> axi_rsp_o.rvalid)
        else $error("read answer missing");
    chk_bvalid_drop: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
        else $error("bvalid held after handshake");
    chk_rvalid_drop: assert property (axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid)
        else $error("rvalid held after handshake");
    chk_aw_block: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
        else $error("write taken during response");
    chk_unmapped_read: assert property ((rd_taken and (axi_req_i.araddr > ADDR_BROADCAST))
        |=> axi_rsp_o.rresp == RESP_SLVERR && axi_rsp_o.rdata == 32'h0) else $error("unmapped read");
    chk_upper_zero: assert property (axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_shift_clock: assert property (rxd_oe_o && $fell(txd_o) |=> txd_o)
        else $error("shift clock low too long");
endmodule : serial_port_control_sva
`default_nettype wire

// ---- tb/serial_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_partner
(
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [10:0] frame_i,
    output var  logic        line_o
);
    int n;
    initial line_o = 1'b1;
    // Sixteen clocks per bit, start bit first
    always @(posedge clk_i)
        if (go_i)
        begin
            for (n = 0; n < 176; n++)
            begin
                line_o <= frame_i[n / 16];
                @(posedge clk_i);
            end
            line_o <= 1'b1;
        end
endmodule : serial_partner
`default_nettype wire

// ---- tb/serial_port_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_port_control_bench;
    import serial_ctrl_pkg::*;
    logic             clk_i;
    logic             rst_b_i;
    axi_lite_req_type q;
    axi_lite_rsp_type r;
    logic             go;
    logic [10:0]      frm;
    logic             rxd;
    logic             ro;
    logic             oe;
    logic             txd;
    logic             irq;
    logic [31:0]      v;
    logic [7:0]       d;
    int               i, k, n_fail, check_count, seed;
    logic [7:0]       sc [4] = '{8'h90, 8'h90, 8'h80, 8'hb0};
    // Pin level seen by the receiver: design wins while it drives
    wire logic        rw = oe ? ro : rxd;
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    serial_port_control dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_req_i(q), .axi_rsp_o(r),
        .t1_overflow_i(1'b0), .rxd_i(rw), .rxd_o(ro), .rxd_oe_o(oe), .txd_o(txd), .irq_o(irq));
    serial_partner peer (.clk_i(clk_i), .go_i(go), .frame_i(frm), .line_o(rxd));
    function automatic logic exp_rx(int n);
        return n < 2;
    endfunction : exp_rx
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task results(input bit to);
        n_fail += to;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task wr(input logic [7:0] a, input logic [31:0] dt);
        logic aw, w, b;
        {aw, w, b} = 3'h7;
        q.awaddr <= a;
        q.wdata <= dt;
        q.wstrb <= 4'hf;
        q.awvalid <= 1'b1;
        q.wvalid <= 1'b1;
        q.bready <= 1'b1;
        for (k = 0; k < 50 && b; k++)
        begin
            // Settled mid-cycle; acted on at the next rising edge
            @(negedge clk_i);
            {aw, w, b} = {aw && !r.awready, w && !r.wready, !r.bvalid};
            @(posedge clk_i);
            if (!aw) q.awvalid <= 1'b0;
            if (!w) q.wvalid <= 1'b0;
        end
        if (k == 50) results(1);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] dt);
        logic ar, rr;
        {ar, rr} = 2'h3;
        q.araddr <= a;
        q.arvalid <= 1'b1;
        q.rready <= 1'b1;
        for (k = 0; k < 50 && rr; k++)
        begin
            @(negedge clk_i);
            {ar, rr} = {ar && !r.arready, !r.rvalid};
            dt = r.rdata;
            @(posedge clk_i);
            if (!ar) q.arvalid <= 1'b0;
        end
        if (k == 50) results(1);
    endtask : rd
    initial
    begin
        seed = 32'hb44e;
        q = '0;
        go = 1'b0;
        frm = '1;
        n_fail = 0;
        check_count = 0;
        rst_b_i = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(ADDR_SERIAL_CONTROL, v);
        chk("reset", v, 32'h0);
        rd(8'h40, v);
        chk("unmapped", v, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h4);
        for (i = 0; i < 4; i++)
        begin
            d = 8'($random(seed)) | 8'h01;
            wr(ADDR_POWER_CONTROL, 32'h80);
            wr(ADDR_SERIAL_CONTROL, {24'h0, sc[i]});
            go <= 1'b1;
            frm <= {i != 0, i[0], d, 1'b0};
            @(posedge clk_i);
            go <= 1'b0;
            repeat (200) @(posedge clk_i);
            wr(ADDR_POWER_CONTROL, 32'hc0);
            rd(ADDR_SERIAL_CONTROL, v);
            chk("fe", v[7], 1'b1);
            chk("rx_done", v[0], exp_rx(i));
            chk("ninth", v[2] & v[0], i[0] & exp_rx(i));
            rd(ADDR_RX_DATA, v);
            if (exp_rx(i)) chk("rx_data", v, d);
            $display("Frame %0d done", i);
        end
        chk("irq_set", irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h7);
        chk("irq_clr", irq, 1'b0);
        wr(ADDR_POWER_CONTROL, 32'h80);
        wr(ADDR_SERIAL_CONTROL, 32'h88);
        wr(ADDR_TX_DATA, {24'h0, d});
        for (k = 0; k < 100 && txd; k++) @(posedge clk_i);
        repeat (150) @(posedge clk_i);
        chk("tx_ninth", txd, 1'b1);
        repeat (40) @(posedge clk_i);
        rd(ADDR_SERIAL_CONTROL, v);
        chk("tx_done", {v[7], v[1]}, 2'h3);
        wr(ADDR_SERIAL_CONTROL, 32'h00);
        wr(ADDR_TX_DATA, 32'h5a);
        repeat (40) @(posedge clk_i);
        rd(ADDR_SERIAL_CONTROL, v);
        chk("m0_done", v[1], 1'b1);
        chk("m0_bit7", v[7], 1'b0);
        $display("Transmit tests done");
        results(0);
    end
endmodule : serial_port_control_bench
bind serial_port_control serial_port_control_sva sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire
